// ==== core/rsfl_pkg.sv ====
// Package for the rail and supply fault latches: offsets, bit positions, resets.
// Assumes an 8-bit register port with byte offsets.
package rsfl_pkg;
  localparam int unsigned RSFL_ADDR_W = 8;
  localparam int unsigned RSFL_DATA_W = 8;
  localparam logic [7:0] RSFL_RAIL34_OFS = 8'h5d;
  localparam logic [7:0] RSFL_SUPPLY_OFS = 8'h62;
  localparam logic [7:0] RSFL_RESET_VAL = 8'h00;
  localparam logic [7:0] RSFL_READ_NONE = 8'h00;
  // Rail fault register bit positions
  localparam int unsigned RSFL_R4_ILIM = 7;
  localparam int unsigned RSFL_R4_SC = 6;
  localparam int unsigned RSFL_R4_UV = 5;
  localparam int unsigned RSFL_R4_OV = 4;
  localparam int unsigned RSFL_R3_ILIM = 3;
  localparam int unsigned RSFL_R3_SC = 2;
  localparam int unsigned RSFL_R3_UV = 1;
  localparam int unsigned RSFL_R3_OV = 0;
  // Supply fault register bit positions
  localparam int unsigned RSFL_M2_RV = 7;
  localparam int unsigned RSFL_M2_UV = 6;
  localparam int unsigned RSFL_M2_OV = 5;
  localparam int unsigned RSFL_M1_RV = 4;
  localparam int unsigned RSFL_M1_UV = 3;
  localparam int unsigned RSFL_M1_OV = 2;
  localparam int unsigned RSFL_VA_UV = 1;
  localparam int unsigned RSFL_VA_OV = 0;
endpackage : rsfl_pkg

// ==== core/rsfl_w1c_reg.sv ====
// One 8-bit latched fault register with write-one-to-clear.
// Assumes event bits are synchronous pulses or levels on clk_sys_in.
`timescale 1ns/10ps
module rsfl_w1c_reg
  import rsfl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Events and clear
  input wire logic [RSFL_DATA_W-1:0] event_in,
  input wire logic clr_en_in,
  input wire logic [RSFL_DATA_W-1:0] clr_data_in,
  // State
  output logic [RSFL_DATA_W-1:0] latch_out
);
  logic [RSFL_DATA_W-1:0] latch_r;
  logic [RSFL_DATA_W-1:0] latch_nxt;

  genvar i;
  generate
    for (i = 0; i < RSFL_DATA_W; i++) begin : g_bit
      // Set beats clear; writing zero keeps the bit
      always_comb begin
        latch_nxt[i] = event_in[i] | (latch_r[i] & ~(clr_en_in & clr_data_in[i])); // R15
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      latch_r <= RSFL_RESET_VAL;
    end else begin
      latch_r <= latch_nxt;
    end
  end

  assign latch_out = latch_r;
endmodule : rsfl_w1c_reg

// ==== core/rsfl_fault_latches.sv ====
// Rail three/four and supply monitor fault latch registers with register port.
// Assumes detector inputs are synchronous to clk_sys_in and active high.
// Assumes one-cycle read and write strobes; read data appears a cycle later.
// How it works
// R1: A current-limit event on rail four sets bit 7, on rail three bit 3, cleared by writing one.
// R2: A short-flag bit (6 rail four, 2 rail three) sets when the output falls below threshold.
// R3: The same short flag sets when the output did not rise above threshold by ramp end.
// R4: The same short flag sets when the output is above threshold before start-up.
// R5: Under-voltage on a rail sets bit 5 or bit 1, cleared by writing one.
// R6: Over-voltage on a rail sets bit 4 or bit 0, cleared by writing one.
// R7: Residual voltage on monitor two sets bit 7, on monitor one bit 4, of the supply register.
// R8: Monitor under-voltage latches bit 6 or 3, with a live bit beside it.
// R9: Monitor over-voltage latches bit 5 or 2, with a live bit beside it.
// R10: Analog supply under-voltage latches bit 1, with a live bit beside it.
// R11: Analog supply over-voltage latches bit 0, with a live bit beside it.
// R12: The rail register sits at 0x5d and resets to zero.
// R13: The supply register sits at 0x62 and resets to zero.
// R14: A summary bit shows while any rail latch is set and clears when all are zero.
// R15: Writing zero leaves a latch alone and a set in the clearing cycle wins.
`timescale 1ns/10ps
module rsfl_fault_latches
  import rsfl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [RSFL_ADDR_W-1:0] reg_addr_in,
  input wire logic [RSFL_DATA_W-1:0] reg_wdata_in,
  output logic [RSFL_DATA_W-1:0] reg_rdata_out,
  // Rail four detector events
  input wire logic rail4_ilim_in,
  input wire logic rail4_sc_run_in,
  input wire logic rail4_sc_ramp_in,
  input wire logic rail4_sc_pre_in,
  input wire logic rail4_uv_in,
  input wire logic rail4_ov_in,
  // Rail three detector events
  input wire logic rail3_ilim_in,
  input wire logic rail3_sc_run_in,
  input wire logic rail3_sc_ramp_in,
  input wire logic rail3_sc_pre_in,
  input wire logic rail3_uv_in,
  input wire logic rail3_ov_in,
  // Supply monitor detector events and live levels
  input wire logic monitor_two_residual_in,
  input wire logic monitor_two_undervolt_in,
  input wire logic monitor_two_overvolt_in,
  input wire logic monitor_one_residual_in,
  input wire logic monitor_one_undervolt_in,
  input wire logic monitor_one_overvolt_in,
  input wire logic analog_supply_undervolt_in,
  input wire logic analog_supply_overvolt_in,
  // Rail summary
  output logic rail34_pending_summary_out,
  // Live monitor levels
  output logic monitor_two_undervolt_live_out,
  output logic monitor_two_overvolt_live_out,
  output logic monitor_one_undervolt_live_out,
  output logic monitor_one_overvolt_live_out,
  output logic analog_supply_undervolt_live_out,
  output logic analog_supply_overvolt_live_out,
  // Latch contents
  output logic [RSFL_DATA_W-1:0] rail34_fault_latches_out,
  output logic [RSFL_DATA_W-1:0] supply_monitor_fault_latches_out
);
  // Event vectors in register bit order
  logic [RSFL_DATA_W-1:0] rail_evt;
  logic [RSFL_DATA_W-1:0] sup_evt;
  // Latch contents
  logic [RSFL_DATA_W-1:0] rail34_fault_latches;
  logic [RSFL_DATA_W-1:0] supply_monitor_fault_latches;
  // Address decode
  logic rail_sel;
  logic sup_sel;
  logic rail_wr;
  logic sup_wr;
  // Output registers
  logic [RSFL_DATA_W-1:0] rdata_r;
  logic [RSFL_DATA_W-1:0] rdata_nxt;
  logic summary_r;
  logic summary_nxt;
  logic m2_uv_live_r;
  logic m2_ov_live_r;
  logic m1_uv_live_r;
  logic m1_ov_live_r;
  logic va_uv_live_r;
  logic va_ov_live_r;

  function automatic logic hit(input logic [RSFL_ADDR_W-1:0] a, input logic [RSFL_ADDR_W-1:0] o);
    hit = (a == o);
  endfunction : hit

  // Short flag raised by any of its three causes
  always_comb begin
    rail_evt = RSFL_RESET_VAL;
    rail_evt[RSFL_R4_ILIM] = rail4_ilim_in; // R1
    rail_evt[RSFL_R3_ILIM] = rail3_ilim_in; // R1
    rail_evt[RSFL_R4_SC] = rail4_sc_run_in; // R2
    rail_evt[RSFL_R3_SC] = rail3_sc_run_in; // R2
    if (rail4_sc_ramp_in | rail4_sc_pre_in) begin
      rail_evt[RSFL_R4_SC] = 1'b1; // R3 R4
    end
    if (rail3_sc_ramp_in | rail3_sc_pre_in) begin
      rail_evt[RSFL_R3_SC] = 1'b1; // R3 R4
    end
    rail_evt[RSFL_R4_UV] = rail4_uv_in; // R5
    rail_evt[RSFL_R3_UV] = rail3_uv_in; // R5
    rail_evt[RSFL_R4_OV] = rail4_ov_in; // R6
    rail_evt[RSFL_R3_OV] = rail3_ov_in; // R6
  end

  // Supply events; residual has no live bit
  always_comb begin
    sup_evt = RSFL_RESET_VAL;
    sup_evt[RSFL_M2_RV] = monitor_two_residual_in; // R7
    sup_evt[RSFL_M1_RV] = monitor_one_residual_in; // R7
    sup_evt[RSFL_M2_UV] = monitor_two_undervolt_in; // R8
    sup_evt[RSFL_M1_UV] = monitor_one_undervolt_in; // R8
    sup_evt[RSFL_M2_OV] = monitor_two_overvolt_in; // R9
    sup_evt[RSFL_M1_OV] = monitor_one_overvolt_in; // R9
    sup_evt[RSFL_VA_UV] = analog_supply_undervolt_in; // R10
    sup_evt[RSFL_VA_OV] = analog_supply_overvolt_in; // R11
  end

  // Writes elsewhere leave both registers alone
  assign rail_sel = hit(reg_addr_in, RSFL_RAIL34_OFS); // R12
  assign sup_sel = hit(reg_addr_in, RSFL_SUPPLY_OFS); // R13
  assign rail_wr = reg_wr_in & rail_sel; // R12
  assign sup_wr = reg_wr_in & sup_sel; // R13

  // Rail and supply latch registers
  rsfl_w1c_reg u_rail (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .event_in (rail_evt),
    .clr_en_in (rail_wr),
    .clr_data_in (reg_wdata_in),
    .latch_out (rail34_fault_latches)
  );

  rsfl_w1c_reg u_supply (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .event_in (sup_evt),
    .clr_en_in (sup_wr),
    .clr_data_in (reg_wdata_in),
    .latch_out (supply_monitor_fault_latches)
  );

  // Read mux; a write in the same cycle is not yet seen
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd_in) begin
      if (rail_sel) begin
        rdata_nxt = rail34_fault_latches; // R12
      end else if (sup_sel) begin
        rdata_nxt = supply_monitor_fault_latches; // R13
      end else begin
        rdata_nxt = RSFL_READ_NONE;
      end
    end
  end

  // Read data registered, held until the next read strobe
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_r <= RSFL_READ_NONE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Summary follows the latches one cycle behind
  assign summary_nxt = |rail34_fault_latches; // R14

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      summary_r <= 1'b0;
    end else begin
      summary_r <= summary_nxt; // R14
    end
  end

  // Live status of the monitor inputs, one cycle late
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      m2_uv_live_r <= 1'b0;
      m2_ov_live_r <= 1'b0;
      m1_uv_live_r <= 1'b0;
      m1_ov_live_r <= 1'b0;
    end else begin
      m2_uv_live_r <= monitor_two_undervolt_in; // R8
      m2_ov_live_r <= monitor_two_overvolt_in; // R9
      m1_uv_live_r <= monitor_one_undervolt_in; // R8
      m1_ov_live_r <= monitor_one_overvolt_in; // R9
    end
  end

  // Live status of the analog supply input, one cycle late
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      va_uv_live_r <= 1'b0;
      va_ov_live_r <= 1'b0;
    end else begin
      va_uv_live_r <= analog_supply_undervolt_in; // R10
      va_ov_live_r <= analog_supply_overvolt_in; // R11
    end
  end

  assign reg_rdata_out = rdata_r;
  assign rail34_pending_summary_out = summary_r;
  assign monitor_two_undervolt_live_out = m2_uv_live_r;
  assign monitor_two_overvolt_live_out = m2_ov_live_r;
  assign monitor_one_undervolt_live_out = m1_uv_live_r;
  assign monitor_one_overvolt_live_out = m1_ov_live_r;
  assign analog_supply_undervolt_live_out = va_uv_live_r;
  assign analog_supply_overvolt_live_out = va_ov_live_r;
  assign rail34_fault_latches_out = rail34_fault_latches;
  assign supply_monitor_fault_latches_out = supply_monitor_fault_latches;
endmodule : rsfl_fault_latches

// ==== sim/rsfl_monitor.sv ====
// Checker of the fault latch timing at the top ports.
// Bound to rsfl_fault_latches; one clock domain, sync reset.
`timescale 1ns/10ps
module rsfl_monitor
  import rsfl_pkg::*;
(
  // Clock
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  // Events
  input wire logic rail4_ilim_in,
  input wire logic rail3_sc_pre_in,
  input wire logic monitor_two_residual_in,
  input wire logic analog_supply_undervolt_in,
  // Status
  input wire logic rail34_pending_summary_out,
  input wire logic analog_supply_undervolt_live_out,
  input wire logic [7:0] rail34_fault_latches_out,
  input wire logic [7:0] supply_monitor_fault_latches_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_ilim_latch: assert property (rail4_ilim_in |=> rail34_fault_latches_out[7])
    else $error("limit not latched");
  a_short_latch: assert property (rail3_sc_pre_in |=> rail34_fault_latches_out[2])
    else $error("short not latched");
  a_resid_latch: assert property (monitor_two_residual_in |=> supply_monitor_fault_latches_out[7])
    else $error("residual not latched");
  a_live_copy: assert property (1'b1 |=> analog_supply_undervolt_live_out == $past(analog_supply_undervolt_in))
    else $error("live bit wrong");
  a_w1c_clear: assert property (reg_wr_in && reg_addr_in == RSFL_SUPPLY_OFS && reg_wdata_in[1]
    && !analog_supply_undervolt_in |=> !supply_monitor_fault_latches_out[1])
    else $error("clear failed");
  a_summary_or: assert property (1'b1 |=> rail34_pending_summary_out == (|$past(rail34_fault_latches_out)))
    else $error("summary wrong");
  a_latch_holds: assert property (!(reg_wr_in && reg_addr_in == RSFL_RAIL34_OFS) |=>
    (rail34_fault_latches_out & $past(rail34_fault_latches_out)) == $past(rail34_fault_latches_out))
    else $error("latch lost");
  a_read_rail: assert property (reg_rd_in && reg_addr_in == RSFL_RAIL34_OFS |=>
    reg_rdata_out == $past(rail34_fault_latches_out))
    else $error("read data wrong");
endmodule : rsfl_monitor
bind rsfl_fault_latches rsfl_monitor rsfl_monitor_i (.*);

// ==== sim/rsfl_fault_latches_bench.sv ====
// Self-checking bench for the rail and supply fault latches.
// Drives register port and detector inputs at the falling edge.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module rsfl_fault_latches_bench
  import rsfl_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out, rail_q, sup_q, ex;
  logic [11:0] rc = 12'h000;
  logic [7:0] sc = 8'h00;
  logic [5:0] live;
  logic summ;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  always #2.5 clk_sys_in = ~clk_sys_in;
  rsfl_fault_latches rsfl_fault_latches_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .rail4_ilim_in(rc[11]), .rail4_sc_run_in(rc[10]),
    .rail4_sc_ramp_in(rc[9]), .rail4_sc_pre_in(rc[8]), .rail4_uv_in(rc[7]), .rail4_ov_in(rc[6]),
    .rail3_ilim_in(rc[5]), .rail3_sc_run_in(rc[4]), .rail3_sc_ramp_in(rc[3]),
    .rail3_sc_pre_in(rc[2]), .rail3_uv_in(rc[1]), .rail3_ov_in(rc[0]),
    .monitor_two_residual_in(sc[7]), .monitor_two_undervolt_in(sc[6]),
    .monitor_two_overvolt_in(sc[5]), .monitor_one_residual_in(sc[4]),
    .monitor_one_undervolt_in(sc[3]), .monitor_one_overvolt_in(sc[2]),
    .analog_supply_undervolt_in(sc[1]), .analog_supply_overvolt_in(sc[0]),
    .rail34_pending_summary_out(summ), .monitor_two_undervolt_live_out(live[5]),
    .monitor_two_overvolt_live_out(live[4]), .monitor_one_undervolt_live_out(live[3]),
    .monitor_one_overvolt_live_out(live[2]), .analog_supply_undervolt_live_out(live[1]),
    .analog_supply_overvolt_live_out(live[0]), .rail34_fault_latches_out(rail_q),
    .supply_monitor_fault_latches_out(sup_q));
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    reg_wr_in = w;
    reg_rd_in = !w;
    reg_addr_in = a;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    @(negedge clk_sys_in);
  endtask : acc
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    `CHK(reg_rdata_out, e)
  endtask : rd
  task automatic complete_run();
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      complete_run();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    rd(RSFL_RAIL34_OFS, RSFL_RESET_VAL);
    rd(RSFL_SUPPLY_OFS, RSFL_RESET_VAL);
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      rc = 12'h001 << i;
      @(negedge clk_sys_in);
      rc = 12'h000;
      ex = 8'h01 << ((i > 5 ? 4 : 0) + (i % 6 == 5 ? 3 : i % 6 > 1 ? 2 : i % 6));
      acc(1'b1, RSFL_RAIL34_OFS, ~ex);
      rd(RSFL_RAIL34_OFS, ex);
      `CHK(rail_q, ex)
      `CHK(summ, 1'b1)
      acc(1'b1, RSFL_RAIL34_OFS, ex);
      rd(RSFL_RAIL34_OFS, 8'h00);
      `CHK(summ, 1'b0)
    end
    $display("rail test done");
    for (int i = 0; i < 8; i++) begin
      sc = 8'h01 << i;
      @(negedge clk_sys_in);
      rd(RSFL_SUPPLY_OFS, sc);
      `CHK(sup_q, sc)
      `CHK(live, {sc[6:5], sc[3:0]})
      acc(1'b1, RSFL_SUPPLY_OFS, sc);
      rd(RSFL_SUPPLY_OFS, sc);
      ex = sc;
      sc = 8'h00;
      acc(1'b1, RSFL_SUPPLY_OFS, ex);
      rd(RSFL_SUPPLY_OFS, 8'h00);
      `CHK(live, 6'h00)
    end
    $display("supply test done");
    sc = 8'hff;
    @(negedge clk_sys_in);
    sc = 8'h00;
    acc(1'b1, 8'h63, 8'hff);
    acc(1'b1, RSFL_RAIL34_OFS, 8'hff);
    rd(RSFL_SUPPLY_OFS, 8'hff);
    rd(8'h63, RSFL_READ_NONE);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    rd(RSFL_SUPPLY_OFS, RSFL_RESET_VAL);
    $display("address and reset test done");
    complete_run();
  end
endmodule : rsfl_fault_latches_bench
